// ---- logic/pfm_pkg.sv ----
// Constants and types shared by the pad function multiplexer.
package pfm_pkg;
  localparam int NUM_PADS = 21;
  localparam logic [1:0] DRIVE_RESET = 2'h2;
  localparam logic [2:0] CODE_INPUT_OFF = 3'h0;
  localparam logic [2:0] CODE_INPUT_ON = 3'h1;
  localparam logic [2:0] CODE_INPUT_PULLDOWN = 3'h2;
  localparam logic [2:0] CODE_INPUT_PULLUP = 3'h3;
  localparam logic [2:0] CODE_OUTPUT_PULLUP = 3'h4;
  localparam logic [1:0] FUNC_ALT = 2'h0;
  localparam logic [1:0] FUNC_GPIO = 2'h1;
  localparam logic [1:0] FUNC_SPI = 2'h2;
  localparam int DEBUG_CLOCK_PAD = 6;
  localparam int STRAP_LOW_PAD = 8;
  localparam int STRAP_HIGH_PAD = 9;
  localparam logic [NUM_PADS-1:0] FLASH_PAD_MASK = 21'h03F800;
  localparam logic [NUM_PADS-1:0] SPI_PAD_MASK = 21'h0004F4;
  localparam logic [NUM_PADS-1:0] ANALOG_PAD_MASK = 21'h00003F;
  typedef enum logic [2:0] {
    PFM_BOOT_UNKNOWN = 3'b001,
    PFM_BOOT_SPI = 3'b010,
    PFM_BOOT_DOWNLOAD = 3'b100
  } pfm_boot_e;
  function automatic logic [2:0] pfm_reset_code(input int pad);
    case (pad)
      0, 1, 11, 18: pfm_reset_code = CODE_INPUT_OFF;
      9, 12, 13, 14, 15, 16, 17, 19: pfm_reset_code = CODE_INPUT_PULLUP;
      20: pfm_reset_code = CODE_OUTPUT_PULLUP;
      default: pfm_reset_code = CODE_INPUT_ON;
    endcase
  endfunction
endpackage

// ---- logic/pfm_code_decode.sv ----
// Decoder from a reset configuration code to pad enables.
`timescale 1ns/1ps
`default_nettype none
module pfm_code_decode (
  // Code in
  input wire logic [2:0] code_i,
  // Enables out
  output logic input_enable_o,
  output logic output_enable_o,
  output logic weak_pullup_o,
  output logic weak_pulldown_o
);
  always_comb begin
    input_enable_o = 1'b0;
    output_enable_o = 1'b0;
    weak_pullup_o = 1'b0;
    weak_pulldown_o = 1'b0;
    case (code_i)
      pfm_pkg::CODE_INPUT_OFF: begin
      end
      pfm_pkg::CODE_INPUT_ON: begin
        input_enable_o = 1'b1;
      end
      pfm_pkg::CODE_INPUT_PULLDOWN: begin
        input_enable_o = 1'b1;
        weak_pulldown_o = 1'b1;
      end
      pfm_pkg::CODE_INPUT_PULLUP: begin
        input_enable_o = 1'b1;
        weak_pullup_o = 1'b1;
      end
      pfm_pkg::CODE_OUTPUT_PULLUP: begin
        output_enable_o = 1'b1;
        weak_pullup_o = 1'b1;
      end
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- logic/pfm_strap_sampler.sv ----
// Boot strap sampler that latches the boot mode at reset release.
`timescale 1ns/1ps
`default_nettype none
module pfm_strap_sampler (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Strap pads
  input wire logic strap_low_i,
  input wire logic strap_high_i,
  // Result
  output logic [2:0] boot_mode_o,
  output logic boot_valid_o
);
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic taken_reg;
  logic taken_next;
  always_comb begin
    mode_next = mode_reg;
    taken_next = taken_reg;
    if (!taken_reg) begin
      taken_next = 1'b1;
      if (strap_high_i) begin
        mode_next = pfm_pkg::PFM_BOOT_SPI;
      end else if (strap_low_i) begin
        mode_next = pfm_pkg::PFM_BOOT_DOWNLOAD;
      end else begin
        mode_next = pfm_pkg::PFM_BOOT_UNKNOWN;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mode_reg <= pfm_pkg::PFM_BOOT_UNKNOWN;
      taken_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      taken_reg <= taken_next;
    end
  end
  assign boot_mode_o = mode_reg;
  assign boot_valid_o = taken_reg;
endmodule
`default_nettype wire

// ---- logic/pfm_pad_function_mux.sv ----
// Pad configuration and function multiplexer for the general-purpose pads.
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_function_mux (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Fuse and part options
  input wire logic debug_pad_disable_fuse_i,
  input wire logic flash_present_i,
  // Software configuration write port
  input wire logic cfg_write_i,
  input wire logic [4:0] cfg_pad_i,
  input wire logic [1:0] cfg_function_i,
  input wire logic [1:0] cfg_drive_i,
  input wire logic cfg_input_enable_i,
  input wire logic cfg_output_enable_i,
  input wire logic cfg_weak_pullup_i,
  input wire logic cfg_weak_pulldown_i,
  input wire logic cfg_spi_direct_i,
  // Peripheral sources per pad
  input wire logic [20:0] gpio_out_i,
  input wire logic [20:0] alt_out_i,
  input wire logic [20:0] matrix_spi_out_i,
  input wire logic spi_controller_mosi_i,
  input wire logic spi_controller_clock_i,
  input wire logic spi_controller_select_i,
  input wire logic spi_controller_hold_i,
  input wire logic spi_controller_protect_i,
  // Pad inputs
  input wire logic [20:0] pad_in_i,
  // Pad controls
  output logic [20:0] pad_out_o,
  output logic [20:0] pad_oe_n_o,
  output logic [20:0] input_enable_o,
  output logic [20:0] weak_pullup_o,
  output logic [20:0] weak_pulldown_o,
  output logic [41:0] drive_o,
  output logic [41:0] function_o,
  // Inputs to peripherals
  output logic [20:0] gpio_in_o,
  output logic spi_controller_miso_o,
  output logic [4:0] converter_one_channel_o,
  output logic converter_two_channel_zero_o,
  // Boot
  output logic [2:0] boot_mode_o,
  output logic boot_valid_o
);
  localparam int N = pfm_pkg::NUM_PADS;
  logic [N-1:0] rst_ie, rst_oe, rst_pu, rst_pd;
  logic [1:0] func_reg [N];
  logic [1:0] func_next [N];
  logic [1:0] drive_reg [N];
  logic [1:0] drive_next [N];
  logic [N-1:0] ie_reg, ie_next, oe_reg, oe_next, pu_reg, pu_next, pd_reg, pd_next;
  logic [N-1:0] out_reg, out_next, gin_reg, gin_next;
  logic [N-1:0] oen_reg, oen_next;
  logic spi_direct_reg, spi_direct_next;
  logic miso_reg, miso_next;
  logic [4:0] adc1_reg, adc1_next;
  logic adc2_reg, adc2_next;
  logic [2:0] boot_mode_w;
  logic boot_valid_w;
  logic [2:0] boot_reg;
  logic bvalid_reg;
  logic [N-1:0] spi_src;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_pad
      logic pu_tab;
      pfm_code_decode u_dec (
        .code_i(pfm_pkg::pfm_reset_code(g)),
        .input_enable_o(rst_ie[g]),
        .output_enable_o(rst_oe[g]),
        .weak_pullup_o(pu_tab),
        .weak_pulldown_o(rst_pd[g])
      );
      if (g == pfm_pkg::DEBUG_CLOCK_PAD) begin : gen_dbg
        assign rst_pu[g] = !debug_pad_disable_fuse_i;
      end else begin : gen_std
        assign rst_pu[g] = pu_tab;
      end
    end
  endgenerate

  // Direct multiplexer sources for function 2 by pad.
  always_comb begin
    spi_src = '0;
    spi_src[4] = spi_controller_hold_i;
    spi_src[5] = spi_controller_protect_i;
    spi_src[6] = spi_controller_clock_i;
    spi_src[7] = spi_controller_mosi_i;
    spi_src[10] = spi_controller_select_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable pad controls
  always_comb begin
    for (int i = 0; i < N; i++) begin
      func_next[i] = func_reg[i];
      drive_next[i] = drive_reg[i];
    end
    ie_next = ie_reg;
    oe_next = oe_reg;
    pu_next = pu_reg;
    pd_next = pd_reg;
    spi_direct_next = cfg_write_i ? cfg_spi_direct_i : spi_direct_reg;
    if (cfg_write_i && (cfg_pad_i < 5'(N))) begin
      func_next[cfg_pad_i] = cfg_function_i;
      if (flash_present_i && pfm_pkg::FLASH_PAD_MASK[cfg_pad_i]) begin
        func_next[cfg_pad_i] = pfm_pkg::FUNC_ALT;
      end
      // function 2 only on SPI pads
      if (cfg_function_i == pfm_pkg::FUNC_SPI && !pfm_pkg::SPI_PAD_MASK[cfg_pad_i]) begin
        func_next[cfg_pad_i] = func_reg[cfg_pad_i];
      end
      drive_next[cfg_pad_i] = cfg_drive_i;
      ie_next[cfg_pad_i] = cfg_input_enable_i;
      oe_next[cfg_pad_i] = cfg_output_enable_i;
      pu_next[cfg_pad_i] = cfg_weak_pullup_i;
      pd_next[cfg_pad_i] = cfg_weak_pulldown_i;
    end
    oen_next = ~oe_next;
  end

  // Output routing through the selected function; GPIO and SPI receive inputs gated by input enable.
  always_comb begin
    out_next = '0;
    gin_next = '0;
    for (int i = 0; i < N; i++) begin
      case (func_reg[i])
        pfm_pkg::FUNC_GPIO: out_next[i] = gpio_out_i[i];
        pfm_pkg::FUNC_SPI: out_next[i] = spi_direct_reg ? spi_src[i] : matrix_spi_out_i[i];
        default: out_next[i] = alt_out_i[i];
      endcase
      gin_next[i] = ie_reg[i] & pad_in_i[i];
    end
    miso_next = (func_reg[2] == pfm_pkg::FUNC_SPI) & ie_reg[2] & pad_in_i[2];
    adc1_next = pad_in_i[4:0] & pfm_pkg::ANALOG_PAD_MASK[4:0];
    adc2_next = pad_in_i[5] & pfm_pkg::ANALOG_PAD_MASK[5];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < N; i++) begin
        func_reg[i] <= pfm_pkg::FUNC_ALT;
        drive_reg[i] <= pfm_pkg::DRIVE_RESET;
      end
      ie_reg <= rst_ie;
      oe_reg <= rst_oe;
      oen_reg <= ~rst_oe;
      pu_reg <= rst_pu;
      pd_reg <= rst_pd;
      out_reg <= '0;
      gin_reg <= '0;
      spi_direct_reg <= 1'b0;
      miso_reg <= 1'b0;
      adc1_reg <= '0;
      adc2_reg <= 1'b0;
      boot_reg <= pfm_pkg::PFM_BOOT_UNKNOWN;
      bvalid_reg <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        func_reg[i] <= func_next[i];
        drive_reg[i] <= drive_next[i];
      end
      ie_reg <= ie_next;
      oe_reg <= oe_next;
      oen_reg <= oen_next;
      pu_reg <= pu_next;
      pd_reg <= pd_next;
      out_reg <= out_next;
      gin_reg <= gin_next;
      spi_direct_reg <= spi_direct_next;
      miso_reg <= miso_next;
      adc1_reg <= adc1_next;
      adc2_reg <= adc2_next;
      boot_reg <= boot_mode_w;
      bvalid_reg <= boot_valid_w;
    end
  end

  // Boot strap sampler on pads 8 and 9.
  pfm_strap_sampler u_strap (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .strap_low_i(pad_in_i[pfm_pkg::STRAP_LOW_PAD]),
    .strap_high_i(pad_in_i[pfm_pkg::STRAP_HIGH_PAD]),
    .boot_mode_o(boot_mode_w),
    .boot_valid_o(boot_valid_w)
  );

  always_comb begin
    for (int i = 0; i < N; i++) begin
      drive_o[2*i +: 2] = drive_reg[i];
      function_o[2*i +: 2] = func_reg[i];
    end
  end
  assign pad_out_o = out_reg;
  assign pad_oe_n_o = oen_reg;
  assign input_enable_o = ie_reg;
  assign weak_pullup_o = pu_reg;
  assign weak_pulldown_o = pd_reg;
  assign gpio_in_o = gin_reg;
  assign spi_controller_miso_o = miso_reg;
  assign converter_one_channel_o = adc1_reg;
  assign converter_two_channel_zero_o = adc2_reg;
  assign boot_mode_o = boot_reg;
  assign boot_valid_o = bvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_drive;
    @(posedge mclk_i) !rstn_i |=> drive_o == {21{2'h2}};
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("drive not 2 after reset");
  property p_reset_cfg;
    @(posedge mclk_i) !rstn_i |=> ie_reg == 21'h0BF7FC && pd_reg == 21'h0 && oe_reg == 21'h100000;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset config wrong");
  property p_reset_pu;
    @(posedge mclk_i) !rstn_i |=> (pu_reg & 21'h1FFFBF) == 21'h1BF200;
  endproperty
  a_reset_pu: assert property (p_reset_pu) else $error("reset pull-up wrong");
  property p_fuse_set;
    @(posedge mclk_i) !rstn_i && debug_pad_disable_fuse_i |=> !pu_reg[6] && ie_reg[6];
  endproperty
  a_fuse_set: assert property (p_fuse_set) else $error("debug clock pad pulled");
  property p_fuse_clr;
    @(posedge mclk_i) !rstn_i && !debug_pad_disable_fuse_i |=> pu_reg[6] && ie_reg[6];
  endproperty
  a_fuse_clr: assert property (p_fuse_clr) else $error("debug clock pad not pulled");
  property p_flash_fixed;
    @(posedge mclk_i) disable iff (!rstn_i)
      cfg_write_i && flash_present_i && cfg_pad_i >= 5'd11 && cfg_pad_i <= 5'd17
      |=> func_reg[$past(cfg_pad_i)] == 2'h0;
  endproperty
  a_flash_fixed: assert property (p_flash_fixed) else $error("flash pad left function 0");
  property p_spi_pads;
    @(posedge mclk_i) disable iff (!rstn_i)
      cfg_write_i && cfg_function_i == 2'h2 && cfg_pad_i == 5'd3 |=> func_reg[3] != 2'h2;
  endproperty
  a_spi_pads: assert property (p_spi_pads) else $error("SPI function on wrong pad");
  property p_write_drive;
    @(posedge mclk_i) disable iff (!rstn_i)
      cfg_write_i && cfg_pad_i == 5'd0 |=> drive_o[1:0] == $past(cfg_drive_i);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("drive write lost");
  property p_boot_spi;
    @(posedge mclk_i) disable iff (!rstn_i)
      $rose(bvalid_reg) && $past(pad_in_i[9], 2) |-> boot_reg == 3'b010;
  endproperty
  a_boot_spi: assert property (p_boot_spi) else $error("boot mode not SPI");
  property p_oe_n_write;
    @(posedge mclk_i) disable iff (!rstn_i)
      cfg_write_i && cfg_pad_i == 5'd20 |=> pad_oe_n_o[20] == !$past(cfg_output_enable_i);
  endproperty
  a_oe_n_write: assert property (p_oe_n_write) else $error("oe_n wrong");
  property p_gpio_in;
    @(posedge mclk_i) disable iff (!rstn_i)
      1'b1 |=> gpio_in_o == ($past(ie_reg) & $past(pad_in_i));
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("input gating wrong");
  property p_analog;
    @(posedge mclk_i) disable iff (!rstn_i)
      1'b1 |=> converter_one_channel_o == $past(pad_in_i[4:0])
        && converter_two_channel_zero_o == $past(pad_in_i[5]);
  endproperty
  a_analog: assert property (p_analog) else $error("converter input wrong");
  property p_miso;
    @(posedge mclk_i) disable iff (!rstn_i)
      1'b1 |=> spi_controller_miso_o
        == ($past(func_reg[2] == 2'h2) && $past(ie_reg[2] && pad_in_i[2]));
  endproperty
  a_miso: assert property (p_miso) else $error("receive line wrong");
  property p_spi_direct;
    @(posedge mclk_i) disable iff (!rstn_i)
      spi_direct_reg && func_reg[7] == 2'h2 |=> pad_out_o[7] == $past(spi_controller_mosi_i);
  endproperty
  a_spi_direct: assert property (p_spi_direct) else $error("direct SPI route wrong");
  property p_gpio_out;
    @(posedge mclk_i) disable iff (!rstn_i)
      func_reg[0] == 2'h1 |=> pad_out_o[0] == $past(gpio_out_i[0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("GPIO route wrong");
  property p_drive_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
      !cfg_write_i |=> drive_o == $past(drive_o);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("drive changed unwritten");
  property p_refused_pad;
    @(posedge mclk_i) disable iff (!rstn_i)
      cfg_write_i && cfg_pad_i > 5'd20 |=> function_o == $past(function_o);
  endproperty
  a_refused_pad: assert property (p_refused_pad) else $error("bad pad index written");
endmodule
`default_nettype wire

// ---- verification/test_pad_function_mux_defaults.sv ----
// Self-checking bench for the pad function multiplexer with a reference model.
`timescale 1ns/1ps
`default_nettype none
module test_pad_function_mux_defaults;
  localparam int NP = 21;
  logic mclk_i, rstn_i, fuse, flash, wr, c_ie, c_oe, c_pu, c_pd, c_dir, miso, conv2, bvalid;
  logic s_mosi, s_clk, s_sel, s_hold, s_prot;
  logic [4:0] c_pad, conv1;
  logic [1:0] c_fn, c_drv;
  logic [20:0] gout, aout, mout, pin, pout, oen, ie, pu, pd, gin;
  logic [41:0] drv, fn;
  logic [2:0] bmode;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int m_fn[NP], m_drv[NP], m_ie[NP], m_oe[NP], m_pu[NP], m_pd[NP];
  int m_dir;

  pfm_pad_function_mux dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .debug_pad_disable_fuse_i(fuse), .flash_present_i(flash),
    .cfg_write_i(wr), .cfg_pad_i(c_pad), .cfg_function_i(c_fn), .cfg_drive_i(c_drv),
    .cfg_input_enable_i(c_ie), .cfg_output_enable_i(c_oe), .cfg_weak_pullup_i(c_pu),
    .cfg_weak_pulldown_i(c_pd), .cfg_spi_direct_i(c_dir), .gpio_out_i(gout),
    .alt_out_i(aout), .matrix_spi_out_i(mout), .spi_controller_mosi_i(s_mosi),
    .spi_controller_clock_i(s_clk), .spi_controller_select_i(s_sel),
    .spi_controller_hold_i(s_hold), .spi_controller_protect_i(s_prot), .pad_in_i(pin),
    .pad_out_o(pout), .pad_oe_n_o(oen), .input_enable_o(ie), .weak_pullup_o(pu),
    .weak_pulldown_o(pd), .drive_o(drv), .function_o(fn), .gpio_in_o(gin),
    .spi_controller_miso_o(miso), .converter_one_channel_o(conv1),
    .converter_two_channel_zero_o(conv2), .boot_mode_o(bmode), .boot_valid_o(bvalid)
  );

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Cuts a hung run short well above the expected length.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_cfg(input logic [1:0] got, input logic [1:0] exp, input int pad);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD cfg t=%0t pad=%0d got=%0h exp=%0h", $time, pad, got, exp);
    end
  endtask

  task automatic chk_data(input logic [4:0] got, input logic [4:0] exp, input int pad);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD data t=%0t pad=%0d got=%0h exp=%0h", $time, pad, got, exp);
    end
  endtask

  task automatic chk_boot(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD boot t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic int rcode(input int p);
    if (p inside {0, 1, 11, 18}) return 0;
    if (p inside {9, [12:17], 19}) return 3;
    if (p == 20) return 4;
    return 1;
  endfunction

  function automatic logic spi_src(input int p);
    return (p == 4) ? s_hold : (p == 5) ? s_prot : (p == 6) ? s_clk :
           (p == 7) ? s_mosi : (p == 10) ? s_sel : 1'b0;
  endfunction

  task automatic check_all();
    for (int p = 0; p < NP; p++) begin
      chk_cfg({1'b0, ie[p]}, 2'(m_ie[p]), p); // input enable
      chk_cfg({pu[p], pd[p]}, {1'(m_pu[p]), 1'(m_pd[p])}, p); // pulls
      chk_cfg({1'b0, oen[p]}, {1'b0, 1'(!m_oe[p])}, p); // output enable
      chk_cfg(drv[2*p+:2], 2'(m_drv[p]), p); // drive
      chk_cfg(fn[2*p+:2], 2'(m_fn[p]), p); // function
    end
  endtask

  task automatic check_data();
    logic e;
    for (int p = 0; p < NP; p++) begin
      e = (m_fn[p] == 0) ? aout[p] : (m_fn[p] == 1) ? gout[p] : m_dir ? spi_src(p) : mout[p];
      chk_data(5'(pout[p]), 5'(e), p); // routing
      chk_data(5'(gin[p]), 5'(pin[p] & 1'(m_ie[p])), p); // input gating
    end
    chk_data(conv1, pin[4:0], 21); // converter one
    chk_data(5'(conv2), 5'(pin[5]), 22); // converter two
    chk_data(5'(miso), 5'((m_fn[2] == 2 && m_ie[2] != 0) ? pin[2] : 1'b0), 2); // receive
  endtask

  task automatic do_reset(input logic f, input logic [1:0] st);
    int c;
    @(negedge mclk_i);
    rstn_i = 1'b0;
    fuse = f;
    pin[9:8] = st;
    repeat (6) @(negedge mclk_i);
    chk_boot(bmode, 3'h1); // held in reset
    chk_boot({2'h0, bvalid}, 3'h0); // not yet valid
    rstn_i = 1'b1;
    for (int p = 0; p < NP; p++) begin
      c = rcode(p);
      m_fn[p] = 0;
      m_drv[p] = 2;
      m_ie[p] = (c inside {1, 2, 3}) ? 1 : 0;
      m_pd[p] = (c == 2) ? 1 : 0;
      m_pu[p] = (c >= 3) ? 1 : 0;
      m_oe[p] = (c == 4) ? 1 : 0;
    end
    m_pu[6] = f ? 0 : 1;
    @(negedge mclk_i);
    check_all(); // defaults
    chk_boot({2'h0, bvalid}, 3'h0); // not valid yet
    @(negedge mclk_i);
    chk_boot(bmode, st[1] ? 3'h2 : (st[0] ? 3'h4 : 3'h1)); // strap
    chk_boot({2'h0, bvalid}, 3'h1); // valid
  endtask

  task automatic burst(input int n);
    int p;
    int f;
    for (int k = 0; k < n; k++) begin
      @(negedge mclk_i);
      p = $urandom_range(22, 0);
      f = $urandom_range(2, 0);
      {c_ie, c_oe, c_pu, c_pd, c_dir, c_drv} = 7'($urandom);
      wr = 1'b1;
      c_pad = 5'(p);
      c_fn = 2'(f);
      m_dir = c_dir;
      if (p < NP) begin
        if (f != 2 || p inside {2, 4, 5, 6, 7, 10}) m_fn[p] = f;
        if (flash && p inside {[11:17]}) m_fn[p] = 0;
        m_drv[p] = c_drv;
        m_ie[p] = c_ie;
        m_oe[p] = c_oe;
        m_pu[p] = c_pu;
        m_pd[p] = c_pd;
      end
    end
    @(negedge mclk_i);
    wr = 1'b0;
    {gout, aout, mout, pin} = {21'($urandom), 21'($urandom), 21'($urandom), 21'($urandom)};
    {s_mosi, s_clk, s_sel, s_hold, s_prot} = 5'($urandom);
    repeat (3) @(negedge mclk_i);
    check_all(); // written controls
    check_data(); // routing
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    {fuse, flash, wr, c_ie, c_oe, c_pu, c_pd, c_dir} = 8'h00;
    {s_mosi, s_clk, s_sel, s_hold, s_prot} = 5'h00;
    {c_pad, c_fn, c_drv} = 9'h000;
    {gout, aout, mout, pin} = 84'h0;
    m_dir = 0;
    void'($urandom(60645));
    do_reset(1'b0, 2'h3);
    $display("test reset defaults done");
    for (int i = 0; i < 4; i++) begin
      do_reset(1'(i), 2'(i));
    end
    $display("test fuse and strap done");
    burst(80);
    $display("test writes without flash done");
    flash = 1'b1;
    do_reset(1'b1, 2'h2);
    burst(80);
    $display("test writes with flash done");
    final_report();
  end
endmodule
`default_nettype wire
